// file: oled_pkg.sv
// Shared types and constants for the display host command decoder
package oled_pkg;

    // Bus styles, coded exactly as the two strap pins read {hi, lo}
    typedef enum logic [1:0] {BUS_SPI4, BUS_SPI3, BUS_P8080, BUS_P6800} bus_mode_e;

    // Display modes, coded as the low two bits of their opcodes
    typedef enum logic [1:0] {DISP_OFF, DISP_ALL_ON, DISP_NORMAL, DISP_INVERSE} disp_mode_e;

    // What following data-phase bytes do
    typedef enum logic [1:0] {ACC_NONE, ACC_WR, ACC_RD} access_e;

    // Decoder states
    typedef enum logic [1:0] {ST_CMD, ST_PARAM1, ST_PARAM2} dec_state_e;

    // Opcodes
    localparam logic [7:0] CMD_GS_ENABLE = 8'h00;
    localparam logic [7:0] CMD_COL_WIN = 8'h15;
    localparam logic [7:0] CMD_ROW_WIN = 8'h75;
    localparam logic [7:0] CMD_RAM_WR = 8'h5C;
    localparam logic [7:0] CMD_RAM_RD = 8'h5D;
    localparam logic [7:0] CMD_REMAP = 8'hA0;
    localparam logic [7:0] CMD_START_LINE = 8'hA1;
    localparam logic [7:0] CMD_OFFSET = 8'hA2;
    localparam logic [7:0] CMD_MODE_FIRST = 8'hA4;
    localparam logic [7:0] CMD_MODE_LAST = 8'hA7;
    localparam logic [7:0] CMD_PART_ON = 8'hA8;
    localparam logic [7:0] CMD_PART_OFF = 8'hA9;
    localparam logic [7:0] CMD_SLEEP_ON = 8'hAE;
    localparam logic [7:0] CMD_SLEEP_OFF = 8'hAF;

    // Parameter byte counts
    localparam logic [1:0] NPAR_0 = 2'h0;
    localparam logic [1:0] NPAR_1 = 2'h1;
    localparam logic [1:0] NPAR_2 = 2'h2;

    // Window and line reset values, and the address step
    localparam logic [6:0] ADDR_ZERO = 7'h00;
    localparam logic [6:0] COL_END_RST = 7'h77;
    localparam logic [6:0] ROW_END_RST = 7'h7F;
    localparam logic [6:0] ADDR_STEP = 7'h01;

    // Remap field positions, first and second parameter
    localparam int REMAP_VERT = 0;
    localparam int REMAP_COLREV = 1;
    localparam int REMAP_NIBBLE = 2;
    localparam int REMAP_SCANREV = 4;
    localparam int REMAP_SPLIT = 5;
    localparam int REMAP_DUAL = 4;

    // Index of the last serial bit in a frame
    localparam logic [3:0] SER_LAST_3W = 4'h8;
    localparam logic [3:0] SER_LAST_4W = 4'h7;

    typedef struct packed {
        logic dc;
        logic [7:0] data;
    } rx_byte_s;

    typedef struct packed {
        logic [6:0] colStart;
        logic [6:0] colEnd;
        logic [6:0] rowStart;
        logic [6:0] rowEnd;
        logic vertInc;
        logic colRemap;
        logic nibbleSwap;
        logic scanReverse;
        logic commonSplit;
        logic dualCommon;
        logic [6:0] startLine;
        logic [6:0] lineOffset;
        disp_mode_e dispMode;
        logic partialOn;
        logic [6:0] partialStart;
        logic [6:0] partialEnd;
        logic sleepOn;
    } settings_s;

    localparam settings_s SETTINGS_RST = '{
        colStart: ADDR_ZERO, colEnd: COL_END_RST,
        rowStart: ADDR_ZERO, rowEnd: ROW_END_RST,
        vertInc: 1'b0, colRemap: 1'b0, nibbleSwap: 1'b0,
        scanReverse: 1'b0, commonSplit: 1'b0, dualCommon: 1'b0,
        startLine: ADDR_ZERO, lineOffset: ADDR_ZERO,
        dispMode: DISP_NORMAL, partialOn: 1'b0,
        partialStart: ADDR_ZERO, partialEnd: ADDR_ZERO,
        sleepOn: 1'b1
    };

endpackage

// file: sync2.sv
// Two-flop synchroniser for a bundle of slow levels
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic clkEn,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (clkEn) begin
            meta_r <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule // sync2

// file: serial_byte_rx.sv
// Serial shifter that runs on the host's serial clock
`timescale 1ns/10ps
module serial_byte_rx import oled_pkg::*; (
    input wire logic serialClk,
    input wire logic resetN,
    input wire logic chipSelectN,
    input wire logic threeWire,
    input wire logic serialDataIn,
    input wire logic dataCmd,
    output rx_byte_s rxWord,
    output logic rxToggle
);
    logic [3:0] bitCnt_r;
    logic [7:0] shift_r;
    logic [3:0] lastBit;

    // Three-wire frames carry the command flag as a ninth, leading bit
    assign lastBit = threeWire ? SER_LAST_3W : SER_LAST_4W;

    // Chip select ends the frame; the clock may stop right after it
    always_ff @(posedge serialClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            bitCnt_r <= 4'h0;
        end else if (bitCnt_r == lastBit) begin
            bitCnt_r <= 4'h0;
        end else begin
            bitCnt_r <= bitCnt_r + 4'h1;
        end
    end

    // Shift in MSB first
    always_ff @(posedge serialClk) begin
        shift_r <= {shift_r[6:0], serialDataIn};
    end

    // Held stable for a whole frame, so the other side may read it after the toggle
    always_ff @(posedge serialClk) begin
        if (!chipSelectN && bitCnt_r == lastBit) begin
            rxWord.data <= {shift_r[6:0], serialDataIn};
            rxWord.dc <= threeWire ? shift_r[7] : dataCmd;
        end
    end

    // One flip per finished byte
    always_ff @(posedge serialClk or negedge resetN) begin
        if (!resetN) begin
            rxToggle <= 1'b0;
        end else if (!chipSelectN && bitCnt_r == lastBit) begin
            rxToggle <= ~rxToggle;
        end
    end
endmodule // serial_byte_rx

// file: oled_host_command_decoder.sv
// Host-port command decoder: bus selection, byte capture, opcode execution
`timescale 1ns/10ps
// How it works
// - Straps pick the bus: 11 E-strobe, 10 RD/WR strobes, 01 3-wire, 00 4-wire.
// - Data/command low marks a command byte, high a data or parameter byte.
// - Transfers count only while chip select is low.
// - Serial clock on data line 0, serial data on line 1; the code takes the clock on a separate serialClk port instead.
// - Opcode 00 makes the loaded grayscale table take effect.
// - Opcode 15 plus two bytes sets column window, reset 0 to 119.
// - Opcode 75 plus two bytes sets row window, reset 0 to 127.
// - After 5C, data bytes are written to RAM inside the window.
// - After 5D, data-phase reads return RAM contents.
// - A0 takes two bytes; first bit 0 picks vertical increment.
// - First-byte bit 1 reverses columns, bit 2 swaps nibbles.
// - First-byte bit 4 reverses row scan direction.
// - First-byte bit 5 enables odd/even common line split.
// - Second-byte bit 4 enables dual common mode; host then clears split.
// - A1 plus one byte sets display start line, reset 0.
// - A2 plus one byte sets vertical offset, reset 0.
// - A4 off, A5 all on, A6 normal, A7 inverse; normal at reset.
// - A8 plus start and end rows turns partial display on.
// - A9 leaves partial display.
// - AE sleeps with display off, AF wakes with display on.
module oled_host_command_decoder import oled_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic serialClk,
    input wire logic busSelectHi,
    input wire logic busSelectLo,
    input wire logic chipSelectN,
    input wire logic dataCmd,
    input wire logic strobeA,
    input wire logic strobeB,
    input wire logic resetN,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    input wire logic [7:0] ramRdData,
    output logic [6:0] ramRow,
    output logic [6:0] ramCol,
    output logic ramWe,
    output logic [6:0] ramWrRow,
    output logic [6:0] ramWrCol,
    output logic [7:0] ramWrData,
    output settings_s settings,
    output logic gsApply,
    output bus_mode_e busMode
);
    localparam int NSYNC = 16;

    logic [NSYNC-1:0] pinSync;
    logic sBsHi, sBsLo, sCsN, sDc, sStrA, sStrB, sResN, sTog;
    logic [7:0] sData;
    rx_byte_s rxWord;
    logic rxToggle;
    logic threeWire;
    logic rstAll;
    logic strA_r, strB_r, togPrev_r;
    logic parMode, is6800;
    logic eFall, rdRise, wrRise;
    logic parWrEvt, serEvt, rdAct, rdEnd;
    logic byteEvt, cmdEvt, dataEvt, lastParam, ramWrEvt;
    rx_byte_s byteVal;
    dec_state_e state_r;
    logic [7:0] opcode_r;
    logic [7:0] p1_r;
    access_e accMode_r;

    // Bytes that a command still expects
    function automatic logic [1:0] paramCount(input logic [7:0] op);
        case (op)
            CMD_COL_WIN, CMD_ROW_WIN, CMD_REMAP, CMD_PART_ON: paramCount = NPAR_2;
            CMD_START_LINE, CMD_OFFSET: paramCount = NPAR_1;
            default: paramCount = NPAR_0;
        endcase
    endfunction

    // Next RAM address, wrapping inside the window in the chosen direction
    function automatic logic [13:0] advance(input logic [6:0] row, input logic [6:0] col,
                                            input settings_s s);
        logic [6:0] r;
        logic [6:0] c;
        r = row;
        c = col;
        if (s.vertInc) begin
            if (row >= s.rowEnd) begin
                r = s.rowStart;
                c = (col >= s.colEnd) ? s.colStart : col + ADDR_STEP;
            end else begin
                r = row + ADDR_STEP;
            end
        end else begin
            if (col >= s.colEnd) begin
                c = s.colStart;
                r = (row >= s.rowEnd) ? s.rowStart : row + ADDR_STEP;
            end else begin
                c = col + ADDR_STEP;
            end
        end
        return {r, c};
    endfunction

    // Every pin and the serial toggle pass two flops before system-clock use; the serial shifter and threeWire take the raw pins
    sync2 #(.W(NSYNC)) pinSyncer (
        .clk(sys_clk),
        .clkEn(clkEn),
        .asyncIn({busSelectHi, busSelectLo, chipSelectN, dataCmd, strobeA, strobeB,
                  resetN, dataIn, rxToggle}),
        .syncOut(pinSync)
    );
    assign {sBsHi, sBsLo, sCsN, sDc, sStrA, sStrB, sResN, sData, sTog} = pinSync;

    // Straps are static, so the serial side may use the raw pins
    assign threeWire = !busSelectHi && busSelectLo;

    // Serial clock comes in on the separate serialClk port, serial data is data line 1
    serial_byte_rx serialRx (
        .serialClk(serialClk),
        .resetN(resetN),
        .chipSelectN(chipSelectN),
        .threeWire(threeWire),
        .serialDataIn(dataIn[1]),
        .dataCmd(dataCmd),
        .rxWord(rxWord),
        .rxToggle(rxToggle)
    );

    // Either reset source returns the block to its initial state
    assign rstAll = reset || !sResN;

    // Bus mode caught while reset is held, so straps may settle first
    always_ff @(posedge sys_clk) begin
        if (rstAll) begin
            busMode <= bus_mode_e'({sBsHi, sBsLo});
        end
    end

    // Strobe history; loaded from the pins in reset to avoid a false edge
    always_ff @(posedge sys_clk) begin
        if (rstAll) begin
            strA_r <= sStrA;
            strB_r <= sStrB;
            togPrev_r <= sTog;
        end else if (clkEn) begin
            strA_r <= sStrA;
            strB_r <= sStrB;
            togPrev_r <= sTog;
        end
    end

    // Strobe decode; strobeA is E or read strobe, strobeB is R/W or write strobe
    assign parMode = (busMode == BUS_P6800) || (busMode == BUS_P8080);
    assign is6800 = busMode == BUS_P6800;
    assign eFall = strA_r && !sStrA;
    assign rdRise = !strA_r && sStrA;
    assign wrRise = !strB_r && sStrB;
    assign parWrEvt = parMode && !sCsN && (is6800 ? (eFall && !sStrB) : wrRise);
    assign rdAct = parMode && !sCsN && (is6800 ? (sStrA && sStrB) : !sStrA);
    assign rdEnd = clkEn && parMode && !sCsN && sDc && (is6800 ? (eFall && sStrB) : rdRise);
    assign serEvt = !parMode && (sTog != togPrev_r);

    // One received byte per event; serial word is stable once its toggle is seen
    assign byteEvt = clkEn && (parWrEvt || serEvt);
    assign byteVal = parMode ? rx_byte_s'({sDc, sData}) : rxWord;
    assign cmdEvt = byteEvt && !byteVal.dc;
    assign dataEvt = byteEvt && byteVal.dc;
    assign lastParam = dataEvt && ((state_r == ST_PARAM2) ||
        (state_r == ST_PARAM1 && paramCount(opcode_r) == NPAR_1));
    assign ramWrEvt = dataEvt && state_r == ST_CMD && accMode_r == ACC_WR;

    // Parameter sequencer; a new command abandons any unfinished one
    always_ff @(posedge sys_clk) begin
        if (rstAll) begin
            state_r <= ST_CMD;
            opcode_r <= CMD_GS_ENABLE;
            p1_r <= 8'h00;
        end else if (cmdEvt) begin
            opcode_r <= byteVal.data;
            state_r <= (paramCount(byteVal.data) == NPAR_0) ? ST_CMD : ST_PARAM1;
        end else if (dataEvt) begin
            unique case (state_r)
                ST_CMD: state_r <= ST_CMD;
                ST_PARAM1: begin
                    p1_r <= byteVal.data;
                    state_r <= (paramCount(opcode_r) == NPAR_1) ? ST_CMD : ST_PARAM2;
                end
                ST_PARAM2: state_r <= ST_CMD;
            endcase
        end
    end

    // Data-phase meaning follows the last RAM opcode; any other command ends it
    always_ff @(posedge sys_clk) begin
        if (rstAll) begin
            accMode_r <= ACC_NONE;
        end else if (cmdEvt) begin
            if (byteVal.data == CMD_RAM_WR) begin
                accMode_r <= ACC_WR;
            end else if (byteVal.data == CMD_RAM_RD) begin
                accMode_r <= ACC_RD;
            end else begin
                accMode_r <= ACC_NONE;
            end
        end
    end

    // Grayscale table take-over pulse
    always_ff @(posedge sys_clk) begin
        if (rstAll) begin
            gsApply <= 1'b0;
        end else if (clkEn) begin
            gsApply <= cmdEvt && byteVal.data == CMD_GS_ENABLE;
        end
    end

    // Single-byte commands act at once, others at their last parameter
    always_ff @(posedge sys_clk) begin
        if (rstAll) begin
            settings <= SETTINGS_RST;
        end else if (cmdEvt) begin
            if (byteVal.data >= CMD_MODE_FIRST && byteVal.data <= CMD_MODE_LAST) begin
                settings.dispMode <= disp_mode_e'(byteVal.data[1:0]);
            end else if (byteVal.data == CMD_PART_OFF) begin
                settings.partialOn <= 1'b0;
            end else if (byteVal.data == CMD_SLEEP_ON) begin
                settings.sleepOn <= 1'b1;
            end else if (byteVal.data == CMD_SLEEP_OFF) begin
                settings.sleepOn <= 1'b0;
            end
        end else if (lastParam) begin
            case (opcode_r)
                CMD_COL_WIN: begin
                    settings.colStart <= p1_r[6:0];
                    settings.colEnd <= byteVal.data[6:0];
                end
                CMD_ROW_WIN: begin
                    settings.rowStart <= p1_r[6:0];
                    settings.rowEnd <= byteVal.data[6:0];
                end
                CMD_REMAP: begin
                    settings.vertInc <= p1_r[REMAP_VERT];
                    settings.colRemap <= p1_r[REMAP_COLREV];
                    settings.nibbleSwap <= p1_r[REMAP_NIBBLE];
                    settings.scanReverse <= p1_r[REMAP_SCANREV];
                    settings.commonSplit <= p1_r[REMAP_SPLIT];
                    settings.dualCommon <= byteVal.data[REMAP_DUAL];
                end
                CMD_START_LINE: settings.startLine <= byteVal.data[6:0];
                CMD_OFFSET: settings.lineOffset <= byteVal.data[6:0];
                CMD_PART_ON: begin
                    settings.partialOn <= 1'b1;
                    settings.partialStart <= p1_r[6:0];
                    settings.partialEnd <= byteVal.data[6:0];
                end
                default: settings.sleepOn <= settings.sleepOn;
            endcase
        end
    end

    // Address pointer: a new window homes it, each access steps it
    always_ff @(posedge sys_clk) begin
        if (rstAll) begin
            ramRow <= ADDR_ZERO;
            ramCol <= ADDR_ZERO;
        end else if (lastParam && opcode_r == CMD_COL_WIN) begin
            ramCol <= p1_r[6:0];
        end else if (lastParam && opcode_r == CMD_ROW_WIN) begin
            ramRow <= p1_r[6:0];
        end else if (ramWrEvt || (rdEnd && accMode_r == ACC_RD)) begin
            {ramRow, ramCol} <= advance(ramRow, ramCol, settings);
        end
    end

    // RAM write port, registered so address and data stand with the strobe
    always_ff @(posedge sys_clk) begin
        if (rstAll) begin
            ramWe <= 1'b0;
            ramWrRow <= ADDR_ZERO;
            ramWrCol <= ADDR_ZERO;
            ramWrData <= 8'h00;
        end else if (clkEn) begin
            ramWe <= ramWrEvt;
            if (ramWrEvt) begin
                ramWrRow <= ramRow;
                ramWrCol <= ramCol;
                ramWrData <= byteVal.data;
            end
        end
    end

    // Read drive: RAM data only in read mode's data phase, else zeros
    always_ff @(posedge sys_clk) begin
        if (rstAll) begin
            dataOe <= 1'b0;
            dataOut <= 8'h00;
        end else if (clkEn) begin
            dataOe <= rdAct;
            dataOut <= (accMode_r == ACC_RD && sDc) ? ramRdData : 8'h00;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence sLastOf(logic [7:0] op);
        state_r == ST_PARAM2 && opcode_r == op && dataEvt;
    endsequence

    sequence sCmd(logic [7:0] op);
        cmdEvt && byteVal.data == op;
    endsequence

    AST_RESET_DEFAULTS: assert property (
        rstAll |=> settings.colEnd == COL_END_RST && settings.rowEnd == ROW_END_RST
            && settings.dispMode == DISP_NORMAL && state_r == ST_CMD)
        else $error("reset did not restore defaults");

    AST_CS_GATES_BUS: assert property (
        parMode && sCsN && !rstAll |=> $stable(settings) && $stable(state_r) && !ramWe)
        else $error("byte taken with chip select high");

    AST_GS_PULSE: assert property (
        sCmd(CMD_GS_ENABLE) |=> gsApply ##1 (!gsApply || $past(cmdEvt)))
        else $error("grayscale enable pulse wrong");

    AST_COL_WINDOW: assert property (
        sLastOf(CMD_COL_WIN) |=> settings.colEnd == $past(byteVal.data[6:0])
            && settings.colStart == $past(p1_r[6:0]) && ramCol == settings.colStart)
        else $error("column window not applied");

    AST_ROW_WINDOW: assert property (
        sLastOf(CMD_ROW_WIN) |=> settings.rowEnd == $past(byteVal.data[6:0])
            && ramRow == settings.rowStart)
        else $error("row window not applied");

    AST_NO_EARLY_APPLY: assert property (
        state_r == ST_PARAM1 && dataEvt && paramCount(opcode_r) == NPAR_2
            |=> $stable(settings) && state_r == ST_PARAM2)
        else $error("setting changed before last parameter");

    AST_RAM_WRITE: assert property (
        ramWrEvt |=> ramWe && ramWrData == $past(byteVal.data)
            && ramWrCol == $past(ramCol))
        else $error("RAM write lost");

    AST_RAM_READ: assert property (
        !rstAll && clkEn && accMode_r == ACC_RD && sDc |=> dataOut == $past(ramRdData))
        else $error("read data not from RAM");

    AST_DISP_MODE: assert property (
        cmdEvt && byteVal.data >= CMD_MODE_FIRST && byteVal.data <= CMD_MODE_LAST
            |=> settings.dispMode == disp_mode_e'($past(byteVal.data[1:0])))
        else $error("display mode not set");

    AST_PARTIAL_OFF: assert property (
        sCmd(CMD_PART_OFF) |=> !settings.partialOn)
        else $error("partial display not left");

    AST_SLEEP: assert property (
        sCmd(CMD_SLEEP_ON) |=> settings.sleepOn)
        else $error("sleep not entered");
endmodule // oled_host_command_decoder

// file: host_model.sv
// Host processor model that drives the controller's bus pins
`timescale 1ns/10ps
module host_model (
    input wire logic sys_clk,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    output logic chipSelectN,
    output logic dataCmd,
    output logic strobeA,
    output logic strobeB,
    output logic resetN,
    output logic serialClk,
    output logic [7:0] dataIn
);
    // Idle bus: strobes inactive, serial clock parked low between frames; a power-up
    // pulse on the reset pin and a rising chip select give the serial shifter a known state
    initial begin
        {chipSelectN, strobeA, strobeB, resetN, dataCmd, serialClk} = 6'h1C;
        dataIn = 8'h00;
        @(negedge sys_clk);
        resetN = 1'b0;
        @(negedge sys_clk);
        {chipSelectN, resetN} = 2'h3;
    end
    // Write strobe low then high, each held long enough for the synchronisers
    task automatic wr(input logic csN, input logic dc, input logic [7:0] d);
        @(negedge sys_clk);
        {chipSelectN, dataCmd, dataIn, strobeB} = {csN, dc, d, 1'b0};
        repeat (5) @(negedge sys_clk);
        strobeB = 1'b1;
        repeat (5) @(negedge sys_clk);
        chipSelectN = 1'b1;
        dataIn = ~d; // Released bus shows no stale byte
    endtask
    // E-strobe style write: R/W low, byte taken when E falls
    task automatic wrE(input logic dc, input logic [7:0] d);
        @(negedge sys_clk);
        {chipSelectN, dataCmd, dataIn, strobeB, strobeA} = {1'b0, dc, d, 2'b01};
        repeat (5) @(negedge sys_clk);
        strobeA = 1'b0;
        repeat (5) @(negedge sys_clk);
        {chipSelectN, strobeA, strobeB} = 3'h7;
    endtask
    // Data-phase read; the byte is taken while the read strobe is still low
    task automatic rd(output logic [7:0] d, output logic oe);
        @(negedge sys_clk);
        {chipSelectN, dataCmd, strobeA} = 3'h2;
        repeat (6) @(negedge sys_clk);
        {oe, d} = {dataOe, dataOut};
        strobeA = 1'b1;
        repeat (6) @(negedge sys_clk);
        chipSelectN = 1'b1;
    endtask
    // One serial frame, MSB first; a 3-wire frame leads with the dc bit
    task automatic ser(input logic three, input logic dc, input logic [7:0] d);
        logic [8:0] f;
        f = three ? {dc, d} : {d, 1'b0};
        @(negedge sys_clk);
        chipSelectN = 1'b0;
        dataCmd = three ? 1'b0 : dc;
        #37;
        for (int i = 0; i < (three ? 9 : 8); i++) begin
            dataIn = {6'h00, f[8 - i], 1'b0};
            #80 serialClk = 1'b1;
            #80 serialClk = 1'b0;
        end
        dataIn = ~dataIn & 8'h02; // Data line no longer holds the last bit
        repeat (3) @(negedge sys_clk);
        chipSelectN = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask
    // Reset pin pulse, long enough to pass the pin synchroniser
    task automatic pinReset();
        @(negedge sys_clk);
        resetN = 1'b0;
        repeat (5) @(negedge sys_clk);
        resetN = 1'b1;
        repeat (5) @(negedge sys_clk);
    endtask
endmodule // host_model

// file: oled_host_command_decoder_tb.sv
// Self-checking bench for the display host command decoder
`timescale 1ns/10ps
module oled_host_command_decoder_tb;
    import oled_pkg::*;
    logic sys_clk, reset, clkEn, serialClk, busSelectHi, busSelectLo, chipSelectN;
    logic dataCmd, strobeA, strobeB, resetN, dataOe, ramWe, gsApply, rdOe;
    logic [7:0] dataIn, dataOut, ramRdData, ramWrData, rdD;
    logic [6:0] ramRow, ramCol, ramWrRow, ramWrCol;
    settings_s settings;
    bus_mode_e busMode;
    int num_errors = 0;
    int cmp_count = 0;
    int gsCnt = 0;
    int weCnt = 0;
    // RAM model: each byte shows the low four bits of its row and column
    assign ramRdData = {ramRow[3:0], ramCol[3:0]};
    oled_host_command_decoder i_dut (.sys_clk, .reset, .clkEn, .serialClk, .busSelectHi,
        .busSelectLo, .chipSelectN, .dataCmd, .strobeA, .strobeB, .resetN, .dataIn,
        .dataOut, .dataOe, .ramRdData, .ramRow, .ramCol, .ramWe, .ramWrRow, .ramWrCol,
        .ramWrData, .settings, .gsApply, .busMode);
    host_model i_host (.sys_clk, .dataOut, .dataOe, .chipSelectN, .dataCmd, .strobeA,
        .strobeB, .resetN, .serialClk, .dataIn);
    // Clock, and pulse counters so one-cycle outputs are never missed
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        gsCnt += (gsApply === 1'b1);
        weCnt += (ramWe === 1'b1);
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Straps are caught while reset is held
    task automatic doReset(input logic [1:0] bs);
        @(negedge sys_clk);
        {busSelectHi, busSelectLo, reset} = {bs, 1'b1};
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic w(input logic dc, input logic [7:0] d);
        i_host.wr(1'b0, dc, d);
    endtask
    // Watchdog: a hang ends the run as a failure
    initial begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        {reset, busSelectHi, busSelectLo, clkEn} = 4'hF;
        for (int m = 3; m >= 0; m--) begin
            doReset(m[1:0]);
            chk(busMode, m[1:0]);
        end
        i_host.ser(1'b0, 1'b0, CMD_START_LINE);
        i_host.ser(1'b0, 1'b1, 8'h2A);
        chk(settings.startLine, 8'h2A);
        doReset(2'h1);
        i_host.ser(1'b1, 1'b0, CMD_OFFSET);
        i_host.ser(1'b1, 1'b1, 8'h15);
        chk(settings.lineOffset, 8'h15);
        doReset(2'h2);
        chk({settings.colStart, settings.colEnd}, {7'd0, 7'd119});
        chk({settings.rowStart, settings.rowEnd}, {7'd0, 7'd127});
        chk({settings.lineOffset, settings.dispMode}, {7'd0, DISP_NORMAL});
        w(1'b0, CMD_COL_WIN);
        w(1'b1, 8'h05);
        chk(settings.colStart, 8'h00);
        w(1'b1, 8'h10);
        chk({settings.colStart, settings.colEnd}, {7'd5, 7'd16});
        w(1'b0, CMD_ROW_WIN);
        w(1'b1, 8'h02);
        w(1'b1, 8'h7E);
        chk({settings.rowStart, settings.rowEnd}, {7'd2, 7'd126});
        // Split is never left set together with dual mode
        w(1'b0, CMD_REMAP);
        w(1'b1, 8'h37);
        w(1'b1, 8'h00);
        chk(settings[37:32], 6'h3E);
        w(1'b0, CMD_REMAP);
        w(1'b1, 8'h16);
        w(1'b1, 8'h10);
        chk(settings[37:32], 6'h1D);
        w(1'b0, CMD_START_LINE);
        w(1'b1, 8'h7F);
        chk(settings.startLine, 8'h7F);
        for (int i = 0; i < 4; i++) begin
            w(1'b0, CMD_MODE_FIRST + 8'(i));
            chk(settings.dispMode, 24'(i));
        end
        w(1'b0, CMD_PART_ON);
        w(1'b1, 8'h10);
        w(1'b1, 8'h20);
        chk({settings.partialOn, settings.partialStart, settings.partialEnd},
            {1'b1, 7'h10, 7'h20});
        w(1'b0, CMD_PART_OFF);
        chk(settings.partialOn, 8'h00);
        w(1'b0, CMD_SLEEP_OFF);
        chk(settings.sleepOn, 8'h00);
        w(1'b0, CMD_SLEEP_ON);
        chk(settings.sleepOn, 8'h01);
        gsCnt = 0;
        w(1'b0, CMD_GS_ENABLE);
        chk(24'(gsCnt), 24'h000001);
        w(1'b0, CMD_RAM_WR);
        weCnt = 0;
        w(1'b1, 8'hA5);
        chk({ramWrRow, ramWrCol, ramWrData}, {7'd2, 7'd5, 8'hA5});
        w(1'b1, 8'h5A);
        chk({weCnt[7:0], ramWrCol, ramWrData}, {8'd2, 7'd6, 8'h5A});
        w(1'b0, CMD_COL_WIN);
        w(1'b1, 8'h03);
        w(1'b1, 8'h0A);
        w(1'b0, CMD_RAM_RD);
        i_host.rd(rdD, rdOe);
        chk({rdOe, rdD}, {1'b1, 8'h23});
        i_host.wr(1'b1, 1'b0, CMD_START_LINE);
        i_host.wr(1'b1, 1'b1, 8'h11);
        chk(settings.startLine, 8'h7F);
        // A write made while the clock enable is low must leave no trace
        clkEn = 1'b0;
        w(1'b0, CMD_SLEEP_OFF);
        clkEn = 1'b1;
        chk(settings.sleepOn, 8'h01);
        w(1'b0, CMD_START_LINE);
        i_host.pinReset();
        w(1'b1, 8'h22);
        chk({settings.startLine, settings.dispMode}, {7'd0, DISP_NORMAL});
        doReset(2'h3);
        i_host.wrE(1'b0, CMD_MODE_FIRST);
        chk(settings.dispMode, DISP_OFF);
        print_verdict();
    end
endmodule // oled_host_command_decoder_tb
